// file: dclk_ctrl.sv
// dual oscillator timing generator and operating mode sequencer
`timescale 1ns/1ps
module dclk_ctrl #(
  parameter int DIV_W = dclk_pkg::DIV_STAGES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic fc_tick,
  input wire logic fs_tick,
  input wire logic cpu_clock_select,
  input wire logic stage7_source_select,
  input wire logic main_osc_enable,
  input wire logic sub_osc_enable,
  input wire logic doze_request,
  input wire logic timing_gen_halt,
  input wire logic [1:0] tick_source_select,
  input wire logic tick_timer_enable,
  input wire logic global_irq_enable,
  input wire logic tick_irq_individual_enable,
  input wire logic wake_irq,
  input wire logic stop_request,
  input wire logic stop_release,
  input wire logic [3:0] instr_cycles,
  input wire logic instr_start,
  output logic main_clk_en,
  output logic [1:0] machine_state,
  output logic cycle_end,
  output logic instr_done,
  output logic [DIV_W-1:0] divider_stages,
  output logic divider_pulse_out,
  output logic tick_irq_latch,
  output logic irq_service,
  output logic resume_next,
  output dclk_pkg::dclk_mode_t mode,
  output dclk_pkg::dclk_status_t status
);
  logic [1:0] prescaler;
  logic [DIV_W-1:0] div_q;
  logic main_sel_slow;
  logic stop_from_fast;
  logic tick_en_at_entry;
  logic tick_prev;
  logic [3:0] cyc_cnt;
  logic [3:0] cyc_len;
  logic busy;
  dclk_pkg::dclk_mode_t next_mode;

  // low-clock modes where the slow oscillator drives the main clock and stage seven
  function automatic logic is_lowclk(input dclk_pkg::dclk_mode_t m);
    return m inside {dclk_pkg::DCLK_LOWCLK_RUN_BOTH_OSC,
                     dclk_pkg::DCLK_LOWCLK_DOZE_BOTH,
                     dclk_pkg::DCLK_LOWCLK_RUN_SUB_ONLY,
                     dclk_pkg::DCLK_LOWCLK_DOZE_SUB,
                     dclk_pkg::DCLK_LOWCLK_DEEP_DOZE};
  endfunction

  function automatic logic is_doze(input dclk_pkg::dclk_mode_t m);
    return m inside {dclk_pkg::DCLK_DOZE_SINGLE, dclk_pkg::DCLK_DOZE_DUAL,
                     dclk_pkg::DCLK_LOWCLK_DOZE_BOTH,
                     dclk_pkg::DCLK_LOWCLK_DOZE_SUB};
  endfunction

  function automatic logic is_deep(input dclk_pkg::dclk_mode_t m);
    return m inside {dclk_pkg::DCLK_DEEP_DOZE_SINGLE,
                     dclk_pkg::DCLK_LOWCLK_DEEP_DOZE};
  endfunction

  wire sub_only = mode inside {dclk_pkg::DCLK_LOWCLK_RUN_SUB_ONLY,
                               dclk_pkg::DCLK_LOWCLK_DOZE_SUB,
                               dclk_pkg::DCLK_LOWCLK_DEEP_DOZE};
  wire halted = (mode == dclk_pkg::DCLK_STOP);
  wire clear_div = halted || (mode == dclk_pkg::DCLK_WARMUP && stop_release)
                   || (stop_request && !halted);
  wire pre_carry = fc_tick && (prescaler == 2'h3);
  wire stage1_in = pre_carry && !sub_only && main_osc_enable;
  // carry out of stage six: falling edge of stage six output
  wire stage6_fall = stage1_in && (&div_q[dclk_pkg::STAGE6-1:0]);
  // warm-up after fast stop forces stage six
  wire warm_fast = (mode == dclk_pkg::DCLK_WARMUP) && stop_from_fast;
  wire stage7_in = is_lowclk(mode) ? fs_tick :
                   warm_fast ? stage6_fall :
                   stage7_source_select ? fs_tick : stage6_fall;

  // ripple counter as carry chain, synchronous form
  logic [DIV_W-1:0] next_div;
  always_comb begin
    logic c;
    c = stage1_in;
    next_div = div_q;
    for (int i = 0; i < DIV_W; i++) begin
      if (i == dclk_pkg::STAGE7 - 1) begin
        c = stage7_in;
      end
      next_div[i] = div_q[i] ^ c;
      c = c && div_q[i];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prescaler <= dclk_pkg::PRESCALE_RESET;
      div_q <= '0;
    end else if (clear_div) begin
      prescaler <= dclk_pkg::PRESCALE_RESET;
      div_q <= '0;
    end else begin
      prescaler <= fc_tick ? prescaler + 2'h1 : prescaler;
      div_q <= next_div;
    end
  end

  // falling edge of chosen tick stage
  wire [4:0] tick_idx = 5'(dclk_pkg::STAGE7 + 2 * tick_source_select);
  wire tick_src = div_q[tick_idx];
  wire tick_fall = tick_prev && !tick_src;

  always_comb begin
    next_mode = mode;
    unique case (mode)
      dclk_pkg::DCLK_FAST_RUN_SINGLE, dclk_pkg::DCLK_FAST_RUN_DUAL: begin
        if (stop_request) begin
          next_mode = dclk_pkg::DCLK_STOP;
        end else if (timing_gen_halt) begin
          next_mode = dclk_pkg::DCLK_DEEP_DOZE_SINGLE;
        end else if (doze_request) begin
          next_mode = sub_osc_enable ? dclk_pkg::DCLK_DOZE_DUAL :
                      dclk_pkg::DCLK_DOZE_SINGLE;
        end else if (sub_osc_enable && cpu_clock_select) begin
          next_mode = dclk_pkg::DCLK_LOWCLK_RUN_BOTH_OSC;
        end else begin
          next_mode = sub_osc_enable ? dclk_pkg::DCLK_FAST_RUN_DUAL :
                      dclk_pkg::DCLK_FAST_RUN_SINGLE;
        end
      end
      dclk_pkg::DCLK_DOZE_SINGLE: begin
        if (wake_irq) next_mode = dclk_pkg::DCLK_FAST_RUN_SINGLE;
      end
      dclk_pkg::DCLK_DOZE_DUAL: begin
        if (wake_irq) next_mode = dclk_pkg::DCLK_FAST_RUN_DUAL;
      end
      dclk_pkg::DCLK_LOWCLK_DOZE_BOTH: begin
        if (wake_irq) next_mode = dclk_pkg::DCLK_LOWCLK_RUN_BOTH_OSC;
      end
      dclk_pkg::DCLK_LOWCLK_DOZE_SUB: begin
        if (wake_irq) next_mode = dclk_pkg::DCLK_LOWCLK_RUN_SUB_ONLY;
      end
      // tick edge returns to fast run, or to sub-only low-clock run from low-clock deep doze
      dclk_pkg::DCLK_DEEP_DOZE_SINGLE: begin
        if (tick_fall) next_mode = dclk_pkg::DCLK_FAST_RUN_SINGLE;
      end
      dclk_pkg::DCLK_LOWCLK_DEEP_DOZE: begin
        if (tick_fall) next_mode = dclk_pkg::DCLK_LOWCLK_RUN_SUB_ONLY;
      end
      dclk_pkg::DCLK_LOWCLK_RUN_BOTH_OSC: begin
        if (stop_request) next_mode = dclk_pkg::DCLK_STOP;
        else if (doze_request) next_mode = dclk_pkg::DCLK_LOWCLK_DOZE_BOTH;
        else if (!cpu_clock_select) next_mode = dclk_pkg::DCLK_FAST_RUN_DUAL;
        else if (!main_osc_enable)
          next_mode = dclk_pkg::DCLK_LOWCLK_RUN_SUB_ONLY;
      end
      dclk_pkg::DCLK_LOWCLK_RUN_SUB_ONLY: begin
        if (stop_request) next_mode = dclk_pkg::DCLK_STOP;
        else if (timing_gen_halt) next_mode = dclk_pkg::DCLK_LOWCLK_DEEP_DOZE;
        else if (doze_request) next_mode = dclk_pkg::DCLK_LOWCLK_DOZE_SUB;
        else if (main_osc_enable)
          next_mode = dclk_pkg::DCLK_LOWCLK_RUN_BOTH_OSC;
      end
      dclk_pkg::DCLK_STOP: begin
        if (stop_release) next_mode = dclk_pkg::DCLK_WARMUP;
      end
      dclk_pkg::DCLK_WARMUP: begin
        if (div_q[dclk_pkg::WARMUP_BIT])
          next_mode = stop_from_fast ? dclk_pkg::DCLK_FAST_RUN_SINGLE :
                      dclk_pkg::DCLK_LOWCLK_RUN_SUB_ONLY;
      end
      default: next_mode = dclk_pkg::DCLK_FAST_RUN_SINGLE;
    endcase
  end

  wire enter_stop = stop_request && !halted &&
                    next_mode == dclk_pkg::DCLK_STOP;
  wire enter_deep = !is_deep(mode) && is_deep(next_mode);
  wire leave_deep = is_deep(mode) && !is_deep(next_mode);
  wire leave_doze = is_doze(mode) && !is_doze(next_mode);
  wire next_sel_slow = is_lowclk(next_mode);
  // switch at a slow tick boundary, or at once back to fast with the sub oscillator off; no short pulse
  // oscillator ticks may coincide, so the slow edge alone decides
  wire sel_change_ok = fs_tick || (!sub_osc_enable && !next_sel_slow);
  wire main_tick = main_sel_slow ? fs_tick : fc_tick;
  wire cpu_runs = !is_doze(mode) && !is_deep(mode) && !halted &&
                  mode != dclk_pkg::DCLK_WARMUP;
  wire [3:0] len_in = (instr_cycles < dclk_pkg::INSTR_LEN_MIN) ?
                      dclk_pkg::INSTR_LEN_MIN :
                      (instr_cycles > dclk_pkg::INSTR_LEN_MAX) ?
                      dclk_pkg::INSTR_LEN_MAX : instr_cycles;
  wire last_state = main_tick && cpu_runs &&
                    machine_state == dclk_pkg::STATE_LAST;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode <= dclk_pkg::DCLK_FAST_RUN_SINGLE;
      main_sel_slow <= 1'b0;
      stop_from_fast <= 1'b1;
      tick_en_at_entry <= 1'b0;
      tick_prev <= 1'b0;
    end else begin
      mode <= next_mode;
      tick_prev <= tick_src;
      if (main_sel_slow != next_sel_slow && sel_change_ok)
        main_sel_slow <= next_sel_slow;
      if (enter_stop) stop_from_fast <= !is_lowclk(mode);
      if (enter_deep) tick_en_at_entry <= tick_timer_enable;
    end
  end

  // instruction of one to ten cycles
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      machine_state <= 2'h0;
      cycle_end <= 1'b0;
      cyc_cnt <= 4'h0;
      cyc_len <= dclk_pkg::INSTR_LEN_MIN;
      busy <= 1'b0;
      instr_done <= 1'b0;
      main_clk_en <= 1'b0;
    end else begin
      main_clk_en <= main_tick && cpu_runs;
      cycle_end <= last_state;
      instr_done <= 1'b0;
      if (main_tick && cpu_runs) machine_state <= machine_state + 2'h1;
      if (instr_start && !busy) begin
        busy <= 1'b1;
        cyc_len <= len_in;
        cyc_cnt <= 4'h0;
      end else if (busy && last_state) begin
        if (cyc_cnt + 4'h1 == cyc_len) begin
          busy <= 1'b0;
          instr_done <= 1'b1;
        end
        cyc_cnt <= cyc_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tick_irq_latch <= 1'b0;
      irq_service <= 1'b0;
      resume_next <= 1'b0;
      divider_pulse_out <= 1'b0;
      divider_stages <= '0;
      status <= '0;
    end else begin
      irq_service <= leave_doze && global_irq_enable;
      resume_next <= leave_doze && !global_irq_enable;
      // set wins over the ack from the irq controller via wake_irq
      if (leave_deep && tick_en_at_entry) tick_irq_latch <= 1'b1;
      else if (wake_irq && irq_service) tick_irq_latch <= 1'b0;
      // deep-doze tick irq needs all three enables
      if (leave_deep) irq_service <= global_irq_enable &&
                                     tick_irq_individual_enable &&
                                     tick_timer_enable;
      divider_pulse_out <= div_q[dclk_pkg::STAGE7];
      divider_stages <= div_q;
      status.cpu_run <= cpu_runs;
      status.wdt_run <= cpu_runs;
      // deep doze keeps only tick timer
      status.periph_run <= !is_deep(next_mode) && !halted;
      status.tbt_run <= !halted;
      status.main_osc_on <= !sub_only && !halted;
      status.sub_osc_on <= sub_osc_enable && !halted;
      status.sub_pins_port <= !sub_osc_enable;
      status.dual_mode <= sub_osc_enable;
    end
  end
endmodule

// file: dclk_ctrl_assertions.sv
// concurrent checks on the clock mode controller ports
`timescale 1ns/1ps
module dclk_ctrl_chk #(
  parameter int DIV_W = dclk_pkg::DIV_STAGES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic wake_irq,
  input wire logic global_irq_enable,
  input wire logic [1:0] machine_state,
  input wire logic [DIV_W-1:0] divider_stages,
  input wire logic divider_pulse_out,
  input wire logic irq_service,
  input wire logic resume_next,
  input wire dclk_pkg::dclk_mode_t mode,
  input wire dclk_pkg::dclk_status_t status
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_wake;
    mode == dclk_pkg::DCLK_DOZE_SINGLE && wake_irq;
  endsequence
  property p_reset_mode;
    $fell(rst) |-> mode == dclk_pkg::DCLK_FAST_RUN_SINGLE;
  endproperty
  a_reset_mode: assert property (p_reset_mode)
    else $error("mode after reset is not single fast run");
  property p_state_step;
    machine_state != $past(machine_state)
      |-> machine_state == $past(machine_state) + 2'h1;
  endproperty
  a_state_step: assert property (p_state_step)
    else $error("machine state skipped a step");
  property p_dvo; divider_pulse_out == divider_stages[7]; endproperty
  a_dvo: assert property (p_dvo)
    else $error("divider output differs from stage seven");
  property p_ripple; $rose(divider_stages[8]) |-> $fell(divider_stages[7]);
  endproperty
  a_ripple: assert property (p_ripple)
    else $error("stage eight rose without stage seven falling");
  // three cycles so the edge that changes mode may still tick once
  property p_low_stages;
    (mode == dclk_pkg::DCLK_LOWCLK_RUN_SUB_ONLY) [*3]
      |-> $stable(divider_stages[5:0]);
  endproperty
  a_low_stages: assert property (p_low_stages)
    else $error("low stages moved in sub-only run");
  property p_doze_halt;
    (mode == dclk_pkg::DCLK_DOZE_SINGLE) [*2]
      |-> !status.cpu_run && !status.wdt_run && status.periph_run;
  endproperty
  a_doze_halt: assert property (p_doze_halt)
    else $error("doze status flags wrong");
  property p_service; s_wake ##0 global_irq_enable |-> ##1 irq_service;
  endproperty
  a_service: assert property (p_service)
    else $error("no service pulse after doze wake");
  property p_resume; s_wake ##0 !global_irq_enable |-> ##1 resume_next;
  endproperty
  a_resume: assert property (p_resume)
    else $error("no resume pulse after doze wake");
endmodule
bind dclk_ctrl dclk_ctrl_chk #(.DIV_W(DIV_W)) u_chk (.clk_sys, .rst,
  .wake_irq, .global_irq_enable, .machine_state, .divider_stages,
  .divider_pulse_out, .irq_service, .resume_next, .mode, .status);

// file: dclk_osc_model.sv
// oscillator stand-in: tick pulses for the fast and slow resonators
`timescale 1ns/1ps
module dclk_osc_model (
  input wire logic clk_sys,
  input wire logic main_on,
  input wire logic sub_on,
  output logic fc_tick,
  output logic fs_tick
);
  logic [2:0] cnt = 3'h0;
  always_ff @(posedge clk_sys) begin
    cnt <= cnt + 3'h1;
  end
  // a disabled oscillator gives no ticks at all, as on silicon
  assign fc_tick = main_on && cnt[0];
  assign fs_tick = sub_on && (cnt == 3'h7);
endmodule

// file: dclk_pkg.sv
// shared constants, mode enum and status struct for the clock mode controller
package dclk_pkg;
  localparam int PRESCALE_STAGES = 2;
  localparam int DIV_STAGES = 21;
  localparam int STAGE7 = 7;
  localparam int STAGE6 = 6;
  localparam int STATES_PER_CYCLE = 4;
  localparam int MAX_INSTR_CYCLES = 10;
  localparam logic [1:0] STATE_LAST = 2'h3;
  localparam logic [3:0] INSTR_LEN_MIN = 4'h1;
  localparam logic [3:0] INSTR_LEN_MAX = 4'hA;
  localparam logic [1:0] PRESCALE_RESET = 2'h0;
  localparam logic [20:0] DIV_RESET = 21'h00000;
  localparam int WARMUP_BIT = 16;

  typedef enum logic [3:0] {
    DCLK_FAST_RUN_SINGLE = 4'h0,
    DCLK_DOZE_SINGLE = 4'h1,
    DCLK_DEEP_DOZE_SINGLE = 4'h3,
    DCLK_FAST_RUN_DUAL = 4'h2,
    DCLK_DOZE_DUAL = 4'h6,
    DCLK_LOWCLK_RUN_BOTH_OSC = 4'h7,
    DCLK_LOWCLK_DOZE_BOTH = 4'h5,
    DCLK_LOWCLK_RUN_SUB_ONLY = 4'h4,
    DCLK_LOWCLK_DOZE_SUB = 4'hC,
    DCLK_LOWCLK_DEEP_DOZE = 4'hD,
    DCLK_STOP = 4'hF,
    DCLK_WARMUP = 4'hE
  } dclk_mode_t;

  typedef struct packed {
    logic cpu_run;
    logic wdt_run;
    logic periph_run;
    logic tbt_run;
    logic main_osc_on;
    logic sub_osc_on;
    logic sub_pins_port;
    logic dual_mode;
  } dclk_status_t;
endpackage

// file: testbench.sv
// self-checking bench for the clock mode controller
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic cpu_clock_select = 1'b0;
  logic main_osc_enable = 1'b1;
  logic sub_osc_enable = 1'b0;
  logic doze_request = 1'b0;
  logic timing_gen_halt = 1'b0;
  logic tick_timer_enable = 1'b0;
  logic global_irq_enable = 1'b0;
  logic wake_irq = 1'b0;
  logic stop_request = 1'b0;
  logic [1:0] wake_flags = 2'h0;
  logic instr_start = 1'b0;
  logic [3:0] instr_cycles = 4'h1;
  logic fc_tick, fs_tick, main_clk_en, cycle_end, instr_done;
  logic divider_pulse_out, tick_irq_latch, irq_service, resume_next;
  logic [1:0] machine_state;
  logic [20:0] divider_stages;
  dclk_pkg::dclk_mode_t mode;
  dclk_pkg::dclk_status_t status;
  int n_fail = 0;
  int cmp_count = 0;
  always #4 clk_sys = ~clk_sys;
  dclk_osc_model osc (.clk_sys, .main_on(main_osc_enable),
    .sub_on(sub_osc_enable), .fc_tick, .fs_tick);
  dclk_ctrl dut (.clk_sys, .rst, .fc_tick, .fs_tick, .cpu_clock_select,
    .stage7_source_select(1'b0), .main_osc_enable, .sub_osc_enable,
    .doze_request, .timing_gen_halt, .tick_source_select(2'h0),
    .tick_timer_enable, .global_irq_enable,
    .tick_irq_individual_enable(1'b1), .wake_irq, .stop_request,
    .stop_release(1'b0), .instr_cycles, .instr_start, .main_clk_en,
    .machine_state, .cycle_end, .instr_done, .divider_stages,
    .divider_pulse_out, .tick_irq_latch, .irq_service, .resume_next,
    .mode, .status);
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // status flags other than periph_run lag mode by one cycle, so status is read one negedge later
  task automatic go(input dclk_pkg::dclk_mode_t m, input logic [7:0] st);
    int i;
    i = 0;
    do begin
      @(negedge clk_sys);
      i++;
    end while (mode !== m && i < 5000);
    check("mode", mode, m);
    // wake pulses stand only in the cycle the mode changes
    wake_flags = {irq_service, resume_next};
    @(negedge clk_sys);
    check("status", status, st);
  endtask
  task automatic t_instr;
    int n [2];
    int i;
    for (int k = 0; k < 2; k++) begin
      i = 0;
      do begin
        @(negedge clk_sys);
        i++;
      end while (cycle_end !== 1'b1 && i < 999);
      @(posedge clk_sys);
      instr_cycles <= k ? 4'hA : 4'h1;
      instr_start <= 1'b1;
      @(posedge clk_sys);
      instr_start <= 1'b0;
      n[k] = 0;
      do begin
        @(negedge clk_sys);
        n[k] += int'(cycle_end === 1'b1);
        i++;
      end while (instr_done !== 1'b1 && i < 3000);
    end
    check("one cycle span", n[0], 1);
    check("cycle span", n[1] - n[0], 9);
    $display("instruction length test done");
  endtask
  task automatic t_doze;
    for (int g = 0; g < 2; g++) begin
      @(posedge clk_sys);
      global_irq_enable <= g[0];
      doze_request <= 1'b1;
      go(dclk_pkg::DCLK_DOZE_SINGLE, 8'h3A);
      @(posedge clk_sys);
      doze_request <= 1'b0;
      wake_irq <= 1'b1;
      go(dclk_pkg::DCLK_FAST_RUN_SINGLE, 8'hFA);
      check("service", wake_flags[1], g[0]);
      check("resume", wake_flags[0], !g[0]);
      @(posedge clk_sys);
      wake_irq <= 1'b0;
    end
    $display("doze test done");
  endtask
  task automatic t_deep;
    for (int e = 0; e < 2; e++) begin
      @(posedge clk_sys);
      tick_timer_enable <= e[0];
      timing_gen_halt <= 1'b1;
      go(dclk_pkg::DCLK_DEEP_DOZE_SINGLE, 8'h1A);
      @(posedge clk_sys);
      timing_gen_halt <= 1'b0;
      go(dclk_pkg::DCLK_FAST_RUN_SINGLE, 8'hFA);
      check("tick latch", tick_irq_latch, e[0]);
      check("deep service", wake_flags[1], e[0]);
    end
    $display("deep doze test done");
  endtask
  task automatic t_dual;
    logic [5:0] d;
    int c;
    @(posedge clk_sys);
    sub_osc_enable <= 1'b1;
    go(dclk_pkg::DCLK_FAST_RUN_DUAL, 8'hFD);
    @(posedge clk_sys);
    cpu_clock_select <= 1'b1;
    go(dclk_pkg::DCLK_LOWCLK_RUN_BOTH_OSC, 8'hFD);
    count_clk(c);
    check("slow ticks", c, 8);
    @(posedge clk_sys);
    main_osc_enable <= 1'b0;
    go(dclk_pkg::DCLK_LOWCLK_RUN_SUB_ONLY, 8'hF5);
    d = divider_stages[5:0];
    repeat (40) @(negedge clk_sys);
    check("low stages", divider_stages[5:0], d);
    @(posedge clk_sys);
    main_osc_enable <= 1'b1;
    go(dclk_pkg::DCLK_LOWCLK_RUN_BOTH_OSC, 8'hFD);
    @(posedge clk_sys);
    cpu_clock_select <= 1'b0;
    go(dclk_pkg::DCLK_FAST_RUN_DUAL, 8'hFD);
    count_clk(c);
    check("fast ticks", c, 32);
    $display("dual clock test done");
  endtask
  // main clock pulses in 64 cycles once the source switch has settled
  task automatic count_clk(output int c);
    c = 0;
    repeat (16) @(negedge clk_sys);
    repeat (64) begin
      @(negedge clk_sys);
      c += int'(main_clk_en === 1'b1);
    end
  endtask
  // stop clears the divider; only a reset leaves it in this bench
  task automatic t_stop;
    @(posedge clk_sys);
    stop_request <= 1'b1;
    go(dclk_pkg::DCLK_STOP, 8'h01);
    check("divider in stop", divider_stages, 21'h0);
    @(posedge clk_sys);
    stop_request <= 1'b0;
    sub_osc_enable <= 1'b0;
    rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    go(dclk_pkg::DCLK_FAST_RUN_SINGLE, 8'hFA);
    $display("stop and reset test done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check("divider in reset", divider_stages, 21'h0);
    @(posedge clk_sys);
    rst <= 1'b0;
    go(dclk_pkg::DCLK_FAST_RUN_SINGLE, 8'hFA);
    $display("reset test done");
    t_instr();
    t_doze();
    t_deep();
    t_dual();
    t_stop();
    summarize();
  end
  // generous bound: deep doze waits dominate at a few thousand cycles
  initial begin
    #600000;
    n_fail++;
    summarize();
  end
endmodule
